/* bench/rla_brk_model.sv */
// Behavioural breaker that moves a few cycles after an open or close command
module rla_brk_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Commands
  input wire logic open_i,
  input wire logic close_i,
  // Position, 1 = closed
  output logic pos_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt;
  logic target;
  // Travel time of the mechanism, so the block never sees an instant move
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_o <= 1'b1;
      cnt <= 3'h0;
      target <= 1'b1;
    end else if (open_i || close_i) begin
      target <= close_i;
      cnt <= 3'h4;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
      if (cnt == 3'h1) pos_o <= target;
    end
  end
endmodule

/* bench/rla_core_sva.sv */
// Port checks of the reclose lock-out block
`include "rla_cfg.svh"
module rla_chk import rla_pkg::*; #(
  parameter int TICK_CYCLES = 10,
  parameter int MIN_TICKS = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Pins and results
  input wire logic reclose_inhibit_input_i,
  input wire logic [3:0] definite_trip_alarm_o,
  input wire rla_ptr_t shot_pointer_o,
  input wire logic final_trip_o,
  input wire logic abort_o,
  input wire logic lockout_o
);
  logic [3:0] al_q;
  logic [31:0] wid [4];
  logic short_fall;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Width of each alarm; the tick phase can cost one tick, hence the slack
  always_ff @(posedge clk_i) begin
    al_q <= rst_i ? 4'h0 : definite_trip_alarm_o;
    for (int k = 0; k < 4; k++) begin
      wid[k] <= (definite_trip_alarm_o[k] && !rst_i) ? wid[k] + 32'h1 : 32'h0;
    end
  end
  // Flag an alarm that falls too soon
  always_comb begin
    short_fall = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (al_q[k] && !definite_trip_alarm_o[k] && wid[k] < (MIN_TICKS - 1) * TICK_CYCLES) short_fall = 1'b1;
    end
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_inh_held;
    reclose_inhibit_input_i [*8];
  endsequence
  property p_ack;
    s_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  property p_ft;
    final_trip_o |-> shot_pointer_o == `RLA_PTR_FINAL && $past(shot_pointer_o) < `RLA_PTR_FINAL;
  endproperty
  property p_ft_alarm;
    final_trip_o |-> definite_trip_alarm_o != 4'h0;
  endproperty
  property p_one;
    final_trip_o |-> $countones(definite_trip_alarm_o & ~$past(definite_trip_alarm_o)) <= 1;
  endproperty
  property p_width;
    !short_fall;
  endproperty
  property p_lock;
    $rose(lockout_o) |-> shot_pointer_o == `RLA_PTR_LOCK;
  endproperty
  property p_inh;
    s_inh_held |-> lockout_o;
  endproperty
  property p_reclaim;
    $fell(lockout_o) |-> shot_pointer_o == `RLA_PTR_FIRST;
  endproperty
  property p_abort;
    abort_o |-> $past(shot_pointer_o) inside {[3'h2:3'h6]} ##1 !abort_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");
  a_ft: assert property (p_ft) else $error("final trip with wrong pointer");
  a_ft_alarm: assert property (p_ft_alarm) else $error("final trip without alarm");
  a_one: assert property (p_one) else $error("several alarms at one trip");
  a_width: assert property (p_width) else $error("alarm too short");
  a_lock: assert property (p_lock) else $error("lock-out without pointer 7");
  a_inh: assert property (p_inh) else $error("inhibit held without lock-out");
  a_reclaim: assert property (p_reclaim) else $error("lock-out ended off pointer 1");
  a_abort: assert property (p_abort) else $error("abort outside a sequence");
endmodule
bind rla_core rla_chk #(.TICK_CYCLES(TICK_CYCLES), .MIN_TICKS(MIN_TICKS)) i_chk (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .reclose_inhibit_input_i(reclose_inhibit_input_i), .definite_trip_alarm_o(definite_trip_alarm_o),
  .shot_pointer_o(shot_pointer_o), .final_trip_o(final_trip_o), .abort_o(abort_o), .lockout_o(lockout_o));

/* bench/tb.sv */
// Self-checking bench of the reclose lock-out block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rla_pkg::*;
  localparam int TK = 10;
  localparam int SUP = 50;
  logic clk_i, rst_i, cyc, stb, we, ack, pos, ptr_load, ft, abort, lock, prot_open, brk_close, dead;
  logic [3:0] sel;
  logic [7:0] adr;
  logic [31:0] wdat, dout, rdat, seed;
  logic [3:0] lines, arm, alarm;
  logic [4:0] src;
  rla_ptr_t ptr_val, ptr;
  int bad_count, comparisons, cyc_n, n, e;
  int dly [4];
  rla_core #(.TICK_CYCLES(TK), .SUP_TICKS(SUP), .MIN_TICKS(3)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dout), .wb_ack_o(ack), .initiation_line_i(lines), .breaker_position_input_i(pos),
    .reclose_inhibit_input_i(src[4]), .final_trip_arm_i(arm), .ptr_load_i(ptr_load), .ptr_value_i(ptr_val),
    .last_shot_done_i(1'b0), .ar_operating_i(1'b0), .dead_time_i(dead), .breaker_fail_i(src[2]),
    .maint_zero_i(1'b0), .remote_open_parameter_i(src[3]), .aux_supply_lost_i(src[0]),
    .self_fault_i(src[1]), .definite_trip_alarm_o(alarm), .shot_pointer_o(ptr), .final_trip_o(ft),
    .abort_o(abort), .lockout_o(lock));
  rla_brk_model i_brk (.clk_i(clk_i), .rst_i(rst_i), .open_i(ft | prot_open), .close_i(brk_close),
    .pos_o(pos));
  // Free-running 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic bit hit(input int k);
    case (k)
      0: return ft === 1'b1;
      1: return abort === 1'b1;
      2: return lock === 1'b0;
      3: return (|alarm) === 1'b1;
      4: return alarm === 4'h0;
      default: return lock === 1'b1;
    endcase
  endfunction
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bounded wait on a result; values are read as settled before each edge
  task automatic wait_for(input int k, input int lim, output int c);
    c = 0;
    while (!hit(k) && c < lim) begin
      @(posedge clk_i);
      c++;
    end
    if (c >= lim) chk("wait", k, 32'hffffffff);
  endtask
  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // One-cycle command to the breaker model, then time for travel and synchronisers
  task automatic brk_cmd(input logic c);
    prot_open <= !c;
    brk_close <= c;
    @(posedge clk_i);
    prot_open <= 1'b0;
    brk_close <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask
  // Hang guard; the longest path needs about 2000 cycles
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    {cyc, stb, we, adr, wdat, sel, lines, arm, src, ptr_load, ptr_val, prot_open, brk_close, dead} = '0;
    rst_i = 1'b1;
    seed = 32'h067997e6;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, then an unmapped word at 0x20
    for (int i = 0; i < 9; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0);
      chk("reg", (i == 0 || i == 6) ? 32'h1 : i < 5 ? 32'ha : i == 5 ? 32'hbb8 : 32'h0, rdat);
    end
    wb(1'b1, 8'h18, 32'hffffffff);
    wb(1'b1, 8'h20, 32'hffffffff);
    wb(1'b0, 8'h18, 32'h0);
    chk("status", 32'h1, rdat);
    // Random final-trip delays per line, short reclaim
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      dly[i] = int'(seed[2:0]) + 2;
      wb(1'b1, 8'(4 + i * 4), 32'(dly[i]));
    end
    wb(1'b1, 8'h14, 32'h5);
    e = (dly[1] < dly[3]) ? dly[1] : dly[3];
    // Lines 2 and 4 at once: the earlier delay trips, line 2 still owns the alarm
    lines <= 4'b1010;
    arm <= 4'b1010;
    wait_for(0, 2000, n);
    chk("ft_time", 32'h1, 32'(n >= (e - 1) * TK && n <= e * TK + 20));
    chk("ptr", 32'h6, ptr);
    chk("alarm", 32'h2, alarm);
    lines <= 4'h0;
    arm <= 4'h0;
    wait_for(5, 50, n);
    chk("ptr", 32'h7, ptr);
    // A neighbour load during lock-out must be ignored
    ptr_val <= 3'h3;
    ptr_load <= 1'b1;
    @(posedge clk_i);
    ptr_load <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("ptr", 32'h7, ptr);
    brk_close <= 1'b1;
    @(posedge clk_i);
    brk_close <= 1'b0;
    wait_for(2, 1000, n);
    chk("ptr", 32'h1, ptr);
    wait_for(4, 300, n);
    chk("alarm", 32'h0, alarm);
    // Protection opens the breaker by itself with line 1 active
    lines <= 4'b0001;
    repeat (4) @(posedge clk_i);
    prot_open <= 1'b1;
    @(posedge clk_i);
    prot_open <= 1'b0;
    wait_for(3, 100, n);
    chk("alarm", 32'h1, alarm);
    lines <= 4'h0;
    brk_close <= 1'b1;
    @(posedge clk_i);
    brk_close <= 1'b0;
    wait_for(4, 300, n);
    wait_for(2, 1000, n);
    // Line 3 held past the supervision time
    lines <= 4'b0100;
    wait_for(3, 1000, n);
    chk("sup_time", 32'h1, 32'(n >= SUP * TK - 20 && n <= SUP * TK + 20));
    chk("alarm", 32'h4, alarm);
    lines <= 4'h0;
    wait_for(4, 300, n);
    // Every abort cause inside a running sequence; k 5 disables reclosing, k 6 closes in the dead time
    for (int k = 0; k < 7; k++) begin
      if (k == 6) brk_cmd(1'b0);
      ptr_val <= 3'h2;
      ptr_load <= 1'b1;
      @(posedge clk_i);
      ptr_load <= 1'b0;
      if (k == 5) begin
        wb(1'b1, 8'h00, 32'h0);
      end else if (k == 6) begin
        dead <= 1'b1;
        brk_close <= 1'b1;
        @(posedge clk_i);
        brk_close <= 1'b0;
      end else begin
        src <= 5'(1 << k);
      end
      wait_for(1, 30, n);
      repeat (10) @(posedge clk_i);
      src <= 5'h0;
      dead <= 1'b0;
      if (k == 5) wb(1'b1, 8'h00, 32'h1);
      wb(1'b0, 8'h1c, 32'h0);
      chk("cause", k == 6 ? 4 : k < 3 ? k + 1 : k + 2, rdat);
      wait_for(2, 1000, n);
      chk("ptr", 32'h1, ptr);
    end
    // Manual close in normal state locks out when so configured
    wb(1'b1, 8'h00, 32'h9);
    brk_cmd(1'b0);
    brk_cmd(1'b1);
    chk("mc_lock", 32'h1, lock);
    wait_for(2, 1000, n);
    // Opening-coil mode: a rising position input is a breaker opening
    wb(1'b1, 8'h00, 32'h7);
    lines <= 4'b0010;
    brk_cmd(1'b0);
    brk_cmd(1'b1);
    wait_for(3, 100, n);
    chk("coil", 32'h2, alarm);
    lines <= 4'h0;
    wb(1'b1, 8'h00, 32'h1);
    wait_for(4, 300, n);
    give_verdict();
  end
endmodule

/* verilog/rla_cfg.svh */
// Offsets, field positions, reset values and timing counts of the reclose lock-out block
`ifndef RLA_CFG_SVH
`define RLA_CFG_SVH
// Clock and time base
`define RLA_CLK_HZ 50000000
`define RLA_TICK_US 10000
`define RLA_TICK_CYCLES ((`RLA_CLK_HZ / 1000000) * `RLA_TICK_US)
// Two-minute supervision and least alarm width
`define RLA_SUPERVISE_S 120
`define RLA_SUPERVISE_TICKS ((`RLA_SUPERVISE_S * 1000000) / `RLA_TICK_US)
`define RLA_ALARM_MIN_MS 200
`define RLA_ALARM_MIN_TICKS (((`RLA_ALARM_MIN_MS * 1000) + `RLA_TICK_US - 1) / `RLA_TICK_US)
// Shot pointer values
`define RLA_PTR_FIRST 3'h1
`define RLA_PTR_FINAL 3'h6
`define RLA_PTR_LOCK 3'h7
// Register byte offsets
`define RLA_OFS_CTRL 8'h00
`define RLA_OFS_FT0 8'h04
`define RLA_OFS_FT1 8'h08
`define RLA_OFS_FT2 8'h0c
`define RLA_OFS_FT3 8'h10
`define RLA_OFS_RECLAIM 8'h14
`define RLA_OFS_STATUS 8'h18
`define RLA_OFS_CAUSE 8'h1c
// Control field positions
`define RLA_CTRL_ENABLE 0
`define RLA_CTRL_POS_A 1
`define RLA_CTRL_POS_B 2
`define RLA_CTRL_MC_LOCK 3
`define RLA_CTRL_MAINT_LOCK 4
// Reset values
`define RLA_CTRL_RESET 5'h01
`define RLA_FT_RESET 16'h000a
`define RLA_RECLAIM_RESET 16'h0bb8
`endif

/* verilog/rla_core.sv */
// Final trip, definite-trip alarm, lock-out and interruption sequencing of an auto-recloser
`include "rla_cfg.svh"
module rla_core #(
  parameter int TICK_CYCLES = `RLA_TICK_CYCLES,
  parameter int SUP_TICKS = `RLA_SUPERVISE_TICKS,
  parameter int MIN_TICKS = `RLA_ALARM_MIN_TICKS,
  parameter int LINES = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins from the field
  input wire logic [LINES-1:0] initiation_line_i,
  input wire logic breaker_position_input_i,
  input wire logic reclose_inhibit_input_i,
  // Neighbouring reclose logic, same clock
  input wire logic [LINES-1:0] final_trip_arm_i,
  input wire logic ptr_load_i,
  input wire rla_pkg::rla_ptr_t ptr_value_i,
  input wire logic last_shot_done_i,
  input wire logic ar_operating_i,
  input wire logic dead_time_i,
  input wire logic breaker_fail_i,
  input wire logic maint_zero_i,
  input wire logic remote_open_parameter_i,
  input wire logic aux_supply_lost_i,
  input wire logic self_fault_i,
  // Results
  output logic [LINES-1:0] definite_trip_alarm_o,
  output rla_pkg::rla_ptr_t shot_pointer_o,
  output logic final_trip_o,
  output logic abort_o,
  output logic lockout_o
);
  import rla_pkg::*;

  logic [4:0] ctrl;
  logic [15:0] ft_delay [0:LINES-1];
  logic [15:0] reclaim_time;
  rla_cause_t cause, next_cause;
  logic [LINES-1:0] line_m, line_s;
  logic pos_m, pos_s, pos_d;
  logic inh_m, inh_s, inh_d;
  logic lock_level_d, enable_d;
  logic [31:0] tick_cnt;
  logic tick;
  logic [LINES-1:0] ft_done, sup_done, trig;
  logic reclaim_on, reclaim_hit;
  logic wb_req;

  // One-hot of the lowest set bit
  function automatic logic [LINES-1:0] lowest(input logic [LINES-1:0] v);
    lowest = v & (~v + LINES'(1));
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // Breaker position chain runs through reset, so a held reset leaves no false edge behind
  always_ff @(posedge clk_i) begin
    pos_m <= breaker_position_input_i;
    pos_s <= pos_m;
    pos_d <= pos_s;
  end

  // Pins come from outside the clock domain; two stages before use, third stage only for edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_m <= '0;
      line_s <= '0;
      inh_m <= 1'b0;
      inh_s <= 1'b0;
      inh_d <= 1'b0;
    end else begin
      line_m <= initiation_line_i;
      line_s <= line_m;
      inh_m <= reclose_inhibit_input_i;
      inh_s <= inh_m;
      inh_d <= inh_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick <= 1'b0;
    end
  end

  // Breaker events; coil mode has no position data, so no close events exist
  logic coil_mode, open_evt, close_evt, manual_close;
  assign coil_mode = ctrl[`RLA_CTRL_POS_A] && ctrl[`RLA_CTRL_POS_B];
  assign open_evt = coil_mode ? (pos_s && !pos_d) : (pos_d && !pos_s);
  assign close_evt = !coil_mode && !pos_d && pos_s;
  assign manual_close = close_evt && !ar_operating_i;

  // Sequence state and lock-out causes
  logic seq_active, enable, lock_level, lock_evt, lock_now, lock_fall;
  assign enable = ctrl[`RLA_CTRL_ENABLE];
  assign seq_active = (shot_pointer_o != `RLA_PTR_FIRST) && (shot_pointer_o != `RLA_PTR_LOCK);
  assign lock_level = !enable || inh_s || (maint_zero_i && ctrl[`RLA_CTRL_MAINT_LOCK]);
  // event lock-out causes; an interruption ends the sequence the same way
  assign lock_evt = (shot_pointer_o == `RLA_PTR_FINAL && (open_evt || breaker_fail_i)) ||
                    last_shot_done_i || breaker_fail_i || (manual_close && seq_active) ||
                    (manual_close && !seq_active && ctrl[`RLA_CTRL_MC_LOCK]) ||
                    (seq_active && next_cause != RLA_CAUSE_NONE);
  assign lock_now = lock_level || lock_evt;
  assign lock_fall = lock_level_d && !lock_level;

  // Final-trip delay timers, one per line, and two-minute supervision
  logic [LINES-1:0] ft_run;
  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_line
      // start-initiated final trip, ignored in lock-out
      assign ft_run[g] = line_s[g] && final_trip_arm_i[g] && enable && !lock_now &&
                         (shot_pointer_o != `RLA_PTR_LOCK) && (shot_pointer_o != `RLA_PTR_FINAL);
      rla_timer #(.W(16)) u_ft (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .run_i(ft_run[g]),
        .limit_i(ft_delay[g]),
        .done_o(ft_done[g])
      );
      rla_timer #(.W(16)) u_sup (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .run_i(line_s[g]),
        .limit_i(16'(SUP_TICKS)),
        .done_o(sup_done[g])
      );
    end
  endgenerate

  // Final trip fires once; a trip alarms the lowest active line, whichever delay ran out, and supervision alarms its own line
  logic ft_fire, self_trip;
  assign ft_fire = |(ft_done & ft_run);
  assign self_trip = open_evt && (|line_s) && !ar_operating_i && (shot_pointer_o != `RLA_PTR_FINAL);
  // lowest active line at the trip moment, whichever delay ran out; each line past supervision alarms on its own bit
  assign trig = (ft_fire ? lowest(line_s) : '0) | (self_trip ? lowest(line_s) : '0) |
                (sup_done & line_s);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      final_trip_o <= 1'b0;
    end else begin
      final_trip_o <= ft_fire;
    end
  end

  // Alarm outputs with least width; the trigger wins over the release
  generate
    for (g = 0; g < LINES; g++) begin : g_alarm
      logic [7:0] width_cnt;
      logic min_met;
      assign min_met = (width_cnt >= 8'(MIN_TICKS));
      // per-line alarm held until fault clears and width met
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          definite_trip_alarm_o[g] <= 1'b0;
          width_cnt <= '0;
        end else if (trig[g]) begin
          definite_trip_alarm_o[g] <= 1'b1;
          width_cnt <= definite_trip_alarm_o[g] ? width_cnt : 8'h00;
        end else if (definite_trip_alarm_o[g]) begin
          definite_trip_alarm_o[g] <= !min_met || line_s[g];
          if (tick && !min_met) begin
            width_cnt <= width_cnt + 8'h01;
          end
        end
      end
    end
  endgenerate

  // Reclaim timer restarts on every close and on cause clearing
  logic reclaim_restart, reclaim_done;
  assign reclaim_restart = close_evt || lock_fall || lock_evt;
  rla_timer #(.W(16)) u_reclaim (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .run_i(reclaim_on && !reclaim_restart && !lock_level),
    .limit_i(reclaim_time),
    .done_o(reclaim_hit)
  );
  assign reclaim_done = reclaim_hit && reclaim_on && !reclaim_restart && !lock_level;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reclaim_on <= 1'b0;
      lock_level_d <= 1'b0;
    end else begin
      lock_level_d <= lock_level;
      if (reclaim_restart) begin
        reclaim_on <= 1'b1;
      end else if (reclaim_done) begin
        reclaim_on <= 1'b0;
      end
    end
  end

  // Shot pointer; lock-out has priority so a level cause keeps it at 7
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shot_pointer_o <= `RLA_PTR_FIRST;
      lockout_o <= 1'b0;
    end else begin
      if (lock_now) begin
        shot_pointer_o <= `RLA_PTR_LOCK;
      end else if (ft_fire) begin
        shot_pointer_o <= `RLA_PTR_FINAL;
      // reclaim expiry returns to first shot
      end else if (reclaim_done) begin
        shot_pointer_o <= `RLA_PTR_FIRST;
      end else if (ptr_load_i && shot_pointer_o != `RLA_PTR_LOCK) begin
        shot_pointer_o <= ptr_value_i;
      end
      lockout_o <= lock_now || (shot_pointer_o == `RLA_PTR_LOCK && !reclaim_done);
    end
  end

  // Interruption cause, highest priority first
  always_comb begin
    next_cause = RLA_CAUSE_NONE;
    if (aux_supply_lost_i) begin
      next_cause = RLA_CAUSE_AUX_LOST;
    end else if (self_fault_i) begin
      next_cause = RLA_CAUSE_SELF_FAULT;
    end else if (breaker_fail_i) begin
      next_cause = RLA_CAUSE_BRK_FAIL;
    end else if (close_evt && dead_time_i) begin
      next_cause = RLA_CAUSE_CLOSE_DEAD;
    end else if (remote_open_parameter_i) begin
      next_cause = RLA_CAUSE_REMOTE_OPEN;
    end else if (inh_s && !inh_d) begin
      next_cause = RLA_CAUSE_INHIBIT;
    end else if (enable_d && !enable) begin
      next_cause = RLA_CAUSE_DISABLED;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause <= RLA_CAUSE_NONE;
      abort_o <= 1'b0;
      enable_d <= 1'b1;
    end else begin
      enable_d <= enable;
      abort_o <= seq_active && (next_cause != RLA_CAUSE_NONE);
      if (seq_active && next_cause != RLA_CAUSE_NONE) begin
        cause <= next_cause;
      end
    end
  end

  // Wishbone slave: one wait state, ack for one cycle, unmapped reads give zero
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `RLA_CTRL_RESET;
      reclaim_time <= `RLA_RECLAIM_RESET;
      for (int i = 0; i < LINES; i++) begin
        ft_delay[i] <= `RLA_FT_RESET;
      end
    end else if (wb_req && wb_we_i) begin
      if (wb_adr_i == `RLA_OFS_CTRL) begin
        ctrl <= 5'(merge({27'h0, ctrl}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `RLA_OFS_FT0) begin
        ft_delay[0] <= 16'(merge({16'h0, ft_delay[0]}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `RLA_OFS_FT1) begin
        ft_delay[1] <= 16'(merge({16'h0, ft_delay[1]}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `RLA_OFS_FT2) begin
        ft_delay[2] <= 16'(merge({16'h0, ft_delay[2]}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `RLA_OFS_FT3) begin
        ft_delay[3] <= 16'(merge({16'h0, ft_delay[3]}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `RLA_OFS_RECLAIM) begin
        reclaim_time <= 16'(merge({16'h0, reclaim_time}, wb_dat_i, wb_sel_i));
      end
    end
  end

  // Register reads, captured with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (wb_req && !wb_we_i) begin
      if (wb_adr_i == `RLA_OFS_CTRL) begin
        wb_dat_o <= {27'h0, ctrl};
      end else if (wb_adr_i == `RLA_OFS_FT0) begin
        wb_dat_o <= {16'h0, ft_delay[0]};
      end else if (wb_adr_i == `RLA_OFS_FT1) begin
        wb_dat_o <= {16'h0, ft_delay[1]};
      end else if (wb_adr_i == `RLA_OFS_FT2) begin
        wb_dat_o <= {16'h0, ft_delay[2]};
      end else if (wb_adr_i == `RLA_OFS_FT3) begin
        wb_dat_o <= {16'h0, ft_delay[3]};
      end else if (wb_adr_i == `RLA_OFS_RECLAIM) begin
        wb_dat_o <= {16'h0, reclaim_time};
      end else if (wb_adr_i == `RLA_OFS_STATUS) begin
        wb_dat_o <= {22'h0, seq_active, lockout_o, definite_trip_alarm_o, 1'b0, shot_pointer_o};
      end else if (wb_adr_i == `RLA_OFS_CAUSE) begin
        wb_dat_o <= {28'h0, cause};
      end else begin
        wb_dat_o <= 32'h0;
      end
    end
  end
endmodule

/* verilog/rla_pkg.sv */
// Types shared by the reclose lock-out block
package rla_pkg;
  typedef logic [2:0] rla_ptr_t;
  typedef enum logic [3:0] {
    RLA_CAUSE_NONE = 4'b0000,
    RLA_CAUSE_AUX_LOST = 4'b0001,
    RLA_CAUSE_SELF_FAULT = 4'b0010,
    RLA_CAUSE_BRK_FAIL = 4'b0011,
    RLA_CAUSE_CLOSE_DEAD = 4'b0100,
    RLA_CAUSE_REMOTE_OPEN = 4'b0101,
    RLA_CAUSE_INHIBIT = 4'b0110,
    RLA_CAUSE_DISABLED = 4'b0111
  } rla_cause_t;
endpackage

/* verilog/rla_timer.sv */
// Tick-enabled delay counter that flags when its limit is reached
module rla_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic [W-1:0] limit_i,
  // Result
  output logic done_o
);
  logic [W-1:0] count;

  // Count ticks while running; dropping run restarts from zero
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      count <= '0;
      done_o <= 1'b0;
    end else begin
      if (tick_i && count < limit_i) begin
        count <= count + W'(1);
      end
      done_o <= (count >= limit_i);
    end
  end
endmodule
